// File: common/row_refresh_pkg.sv
// Package with register map, field layout and timing constants of the row refresh block.
package row_refresh_pkg;

	// Register byte offsets on the APB slave.
	localparam logic [7:0] OFS_BRIGHT = 8'h00;
	localparam logic [7:0] OFS_CLKCFG = 8'h04;
	localparam logic [7:0] OFS_DOT_BASE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h30;

	// Brightness control word fields.
	localparam int PWM_LSB = 0;
	localparam int PWM_W = 4;
	localparam int PEAK_LSB = 4;
	localparam int PEAK_W = 2;
	localparam int AWAKE_BIT = 6;
	localparam int CW_W = 7;

	// Clock configuration fields.
	localparam int EXT_SEL_BIT = 0;
	localparam int PRESCALE_BIT = 1;

	// Matrix geometry.
	localparam int ROWS = 8;
	localparam int COLS = 20;
	localparam int ROW_W = 3;
	localparam int SLOT_W = 6;

	// Refresh timing in display clock cycles, then the display clock divide ratios.
	localparam int FRAME_CYCLES = 512;
	localparam int SLOT_CYCLES = FRAME_CYCLES / ROWS;
	localparam int BLANK_CYCLES = 4;
	localparam int LIT_MAX = SLOT_CYCLES - BLANK_CYCLES;
	localparam int PRESCALE_DIV = 8;
	localparam int INT_OSC_DIV = 125;

	// Reset values.
	localparam logic [CW_W-1:0] BRIGHT_RST = 7'h00;
	localparam logic [1:0] CLKCFG_RST = 2'h0;

	// Scan machine states, Gray coded.
	typedef enum logic [1:0] {
		ST_SLEEP = 2'b00,
		ST_LIT = 2'b01,
		ST_BLANK = 2'b11
	} scan_e;

	// On-cycles out of 64 per PWM code, rounded to whole display clocks.
	function automatic logic [SLOT_W-1:0] pwm_on(input logic [PWM_W-1:0] c);
		logic [5:0] t [16];
		t = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h09,
			6'h0c, 6'h10, 6'h15, 6'h1c, 6'h24, 6'h24, 6'h2d, 6'h3c};
		// Code 1101 gives 36 cycles, 60% of the 60-cycle maximum.
		pwm_on = t[c];
	endfunction : pwm_on

endpackage : row_refresh_pkg

// File: hdl/led_matrix_row_refresh.sv
// Row-scanning refresh of a 20 by 8 LED matrix with APB register access.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module led_matrix_row_refresh
	import row_refresh_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_osc,
	output logic [ROWS-1:0] row_sink_en,
	output logic [COLS-1:0] col_src_en,
	output logic [PEAK_W-1:0] peak_sel,
	output logic osc_run
);

	typedef struct packed {
		logic [CW_W-1:0] bright;
		logic [1:0] clkcfg;
		logic [ROWS-1:0][COLS-1:0] dots;
		scan_e st;
		logic [ROW_W-1:0] row;
		logic [SLOT_W-1:0] slot;
		logic [6:0] int_div;
		logic [2:0] pre_div;
		logic ext_q;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [ROWS-1:0] row_en;
		logic [COLS-1:0] col_en;
		logic [PEAK_W-1:0] peak;
		logic osc_run;
	} state_s;

	state_s cur_ff;
	state_s nxt_st;

	// True when the address hits one of the eight dot row words.
	function automatic logic is_dot(input logic [7:0] a);
		is_dot = (a >= OFS_DOT_BASE) &&
			(a < OFS_DOT_BASE + 8'(ROWS * 4)) && (a[1:0] == 2'b00);
	endfunction : is_dot

	// Row index of a dot row address.
	function automatic logic [ROW_W-1:0] dot_row(input logic [7:0] a);
		logic [7:0] d;
		d = a - OFS_DOT_BASE;
		dot_row = d[ROW_W+1:2];
	endfunction : dot_row

	logic awake;
	logic disp_tick;
	logic ext_rise;
	logic access;
	logic [SLOT_W-1:0] on_cycles;

	// Display clock enable: internal divider or external edge, optionally /8.
	always_comb begin
		awake = cur_ff.bright[AWAKE_BIT];
		ext_rise = ext_osc & ~cur_ff.ext_q;
		access = psel & penable & ~cur_ff.pready;
		on_cycles = pwm_on(cur_ff.bright[PWM_LSB +: PWM_W]);
		if (cur_ff.clkcfg[EXT_SEL_BIT]) begin
			if (cur_ff.clkcfg[PRESCALE_BIT]) begin
				disp_tick = ext_rise &&
					(cur_ff.pre_div == 3'(PRESCALE_DIV - 1));
			end else begin
				disp_tick = ext_rise;
			end
		end else begin
			disp_tick = awake && (cur_ff.int_div == 7'(INT_OSC_DIV - 1));
		end
	end

	// Next state: bus slave, clock dividers and the row scan.
	always_comb begin
		nxt_st = cur_ff;
		nxt_st.ext_q = ext_osc;
		nxt_st.pready = 1'b0;
		nxt_st.pslverr = 1'b0;

		// Bus access answers one cycle after the access phase begins.
		if (access) begin
			nxt_st.pready = 1'b1;
			nxt_st.prdata = 32'h0000_0000;
			if (paddr == OFS_BRIGHT) begin
				if (pwrite) begin
					nxt_st.bright = pwdata[CW_W-1:0];
				end
				nxt_st.prdata = {25'h0, cur_ff.bright};
			end else if (paddr == OFS_CLKCFG) begin
				if (pwrite) begin
					nxt_st.clkcfg = pwdata[1:0];
				end
				nxt_st.prdata = {30'h0, cur_ff.clkcfg};
			end else if (is_dot(paddr)) begin
				if (pwrite) begin
					nxt_st.dots[dot_row(paddr)] = pwdata[COLS-1:0];
				end
				nxt_st.prdata = {12'h0, cur_ff.dots[dot_row(paddr)]};
			end else if (paddr == OFS_STATUS) begin
				nxt_st.prdata = {22'h0, cur_ff.st, cur_ff.row,
					cur_ff.slot[SLOT_W-1:1]};
				nxt_st.pslverr = pwrite;
			end else begin
				nxt_st.pslverr = 1'b1;
			end
		end

		// Internal oscillator runs only while awake.
		if (!awake || cur_ff.int_div == 7'(INT_OSC_DIV - 1)) begin
			nxt_st.int_div = 7'h00;
		end else begin
			nxt_st.int_div = cur_ff.int_div + 7'h01;
		end
		if (ext_rise) begin
			nxt_st.pre_div = cur_ff.pre_div + 3'h1;
		end

		nxt_st.osc_run = awake;
		if (!awake) begin
			nxt_st.st = ST_SLEEP;
			nxt_st.row = '0;
			nxt_st.slot = '0;
		end else if (cur_ff.st == ST_SLEEP) begin
			nxt_st.st = ST_LIT;
		end else if (disp_tick) begin
			nxt_st.slot = cur_ff.slot + 6'h01;
			if (cur_ff.slot == 6'(SLOT_CYCLES - 1)) begin
				nxt_st.row = cur_ff.row + 3'h1;
			end
			if (nxt_st.slot >= 6'(LIT_MAX)) begin
				nxt_st.st = ST_BLANK;
			end else begin
				nxt_st.st = ST_LIT;
			end
		end

		// Drive outputs from the next scan position so they stay aligned.
		nxt_st.row_en = '0;
		nxt_st.col_en = '0;
		nxt_st.peak = cur_ff.bright[PEAK_LSB +: PEAK_W];
		// one row at a time
		// The row sink stays on through the blank so a slot spans 64 ticks.
		if (nxt_st.st != ST_SLEEP) begin
			nxt_st.row_en[nxt_st.row] = 1'b1;
		end
		if (nxt_st.st == ST_LIT) begin
			if (nxt_st.slot < on_cycles) begin
				nxt_st.col_en = cur_ff.dots[nxt_st.row];
			end
		end
		if (nxt_st.st == ST_BLANK) begin
			nxt_st.col_en = '0;
		end
		if (!awake) begin
			nxt_st.peak = '0;
		end
	end

	// Single state register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_ff <= '{bright: BRIGHT_RST, clkcfg: CLKCFG_RST,
				st: ST_SLEEP, default: '0};
		end else begin
			cur_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register.
	always_comb begin
		prdata = cur_ff.prdata;
		pready = cur_ff.pready;
		pslverr = cur_ff.pslverr;
		row_sink_en = cur_ff.row_en;
		col_src_en = cur_ff.col_en;
		peak_sel = cur_ff.peak;
		osc_run = cur_ff.osc_run;
	end

endmodule : led_matrix_row_refresh

// File: sim/ext_osc_model.sv
// Model of the external display oscillator.
`timescale 1ns/10ps
module ext_osc_model (
	input wire logic pclk,
	input wire logic [7:0] half,
	output logic ext_osc = 1'b0
);
	logic [7:0] cnt = 8'h00;
	// rate limits
	// Toggles every half pclk cycles; the bench keeps the rate legal.
	always @(posedge pclk) begin
		cnt <= (cnt + 8'h01 < half) ? cnt + 8'h01 : 8'h00;
		ext_osc <= (cnt + 8'h01 < half) ? ext_osc : ~ext_osc;
	end
endmodule : ext_osc_model

// File: sim/row_refresh_props.sv
// Checker of row scan and bus timing at the block ports.
`timescale 1ns/10ps
module row_refresh_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic osc_run,
	input wire logic [7:0] row_sink_en,
	input wire logic [19:0] col_src_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A move between two lit rows; waking from sleep is not a step.
	sequence s_step;
		|$past(row_sink_en) && |row_sink_en && $changed(row_sink_en);
	endsequence
	property p_one; $onehot0(row_sink_en); endproperty
	a_one: assert property (p_one) else $error("rows overlap");
	property p_next;
		s_step |-> $past(row_sink_en) == 8'({row_sink_en, row_sink_en} >> 1);
	endproperty
	a_next: assert property (p_next) else $error("row order");
	property p_dwell; s_step |=> $stable(row_sink_en) [*8]; endproperty
	a_dwell: assert property (p_dwell) else $error("short slot");
	property p_blank;
		s_step |-> !(|$past(col_src_en)) && !(|$past(col_src_en, 4));
	endproperty
	a_blank: assert property (p_blank) else $error("no blank");
	property p_wide; |col_src_en |-> |row_sink_en; endproperty
	a_wide: assert property (p_wide) else $error("cols alone");
	property p_off;
		!osc_run [*2] |-> !(|row_sink_en || |col_src_en);
	endproperty
	a_off: assert property (p_off) else $error("lit asleep");
	property p_ack; psel && penable && !pready |=> pready; endproperty
	a_ack: assert property (p_ack) else $error("late ready");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("long ready");
endmodule : row_refresh_props
bind led_matrix_row_refresh row_refresh_props i_row_refresh_props (.*);

// File: sim/tb_led_matrix_row_refresh.sv
// Self-checking bench of the LED matrix row refresh block.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %0t: %0h not %0h", $time, g, e); end end
module tb_led_matrix_row_refresh import row_refresh_pkg::*;;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, ext_osc, osc_run;
	logic [7:0] paddr, row_sink_en, half;
	logic [31:0] pwdata, prdata, s;
	logic [19:0] col_src_en, dot [8];
	logic [1:0] peak_sel;
	logic [6:0] w;
	int on_t [4] = '{36, 60, 12, 0};
	int n_errors = 0;
	int compares = 0;
	led_matrix_row_refresh i_led_matrix_row_refresh (.*);
	ext_osc_model i_ext_osc_model (.*);
	// Next value of the pseudo-random source.
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	// APB transfer, held until ready is sampled high.
	task automatic rw(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : rw
	// Measures one whole row slot and its lit span in pclk cycles.
	task automatic slot(input int p, input int on);
		int len = 0;
		int lit = 0;
		logic [7:0] r = row_sink_en;
		while (row_sink_en === r) @(posedge pclk);
		r = row_sink_en;
		do begin
			len++;
			lit += int'(|col_src_en);
			if (|col_src_en) `CHK(col_src_en, dot[$clog2(r)])
			@(posedge pclk);
		end while (row_sink_en === r);
		`CHK(len, 64 * p)
		`CHK(lit, on * p)
		`CHK(peak_sel, w[5:4])
	endtask : slot
	// Prints the verdict and ends the run.
	task test_done;
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	// Clock of 8 ns.
	initial forever #4 pclk = ~pclk;
	// Watchdog at 100k cycles, well past the expected 65k.
	initial begin
		#800000;
		n_errors++;
		test_done;
	end
	// Random dots, then external, prescaled and internal display clocks.
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		half = 8'd63;
		s = 32'h1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			s = lfsr(s);
			dot[i] = s[19:0] | 20'h1;
			rw(1'b1, OFS_DOT_BASE + 8'(4 * i), 32'(dot[i]));
		end
		for (int i = 0; i < 4; i++) begin
			half <= (i == 2) ? 8'd8 : 8'd63;
			w = {1'b1, 2'(i), 4'(16'h08fd >> (4 * i))};
			rw(1'b1, OFS_CLKCFG, {30'h0, i == 2, i < 3});
			rw(1'b1, OFS_BRIGHT, 32'(w));
			rw(1'b0, OFS_BRIGHT, 32'h0);
			`CHK(prdata[6:0], w)
			slot((i == 2) ? 128 : 126 - (i == 3), on_t[i]);
		end
		rw(1'b1, OFS_STATUS, 32'h0);
		`CHK(pslverr, 1'b1)
		rw(1'b0, 8'h0c, 32'h0);
		`CHK(pslverr, 1'b1)
		rw(1'b0, OFS_STATUS, 32'h0);
		`CHK(pslverr, 1'b0)
		`CHK(prdata[9:8], 2'b01 | {prdata[9], 1'b0})
		rw(1'b1, OFS_BRIGHT, 32'h0);
		repeat (3) @(posedge pclk);
		`CHK(osc_run, 1'b0)
		`CHK(row_sink_en, 8'h00)
		`CHK(col_src_en, 20'h0)
		`CHK(peak_sel, 2'b00)
		test_done;
	end
endmodule : tb_led_matrix_row_refresh
